// *** dual_fifo_flag_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "dfs_consts.svh"

module dual_fifo_flag_sync #(
  parameter int DEPTH = `QUEUE_WORDS,
  parameter int WIDTH = `DATA_BITS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_direction,
  input wire logic port_a_mailbox_sel,
  input wire logic port_a_enable,
  input wire logic [WIDTH-1:0] port_a_data_in,
  output logic [WIDTH-1:0] port_a_data_out,
  output logic port_a_out_ready,
  output logic port_a_in_ready,
  output logic port_a_almost_empty_n,
  output logic port_a_almost_full_n,
  input wire logic port_b_clock,
  input wire logic port_b_select_n,
  input wire logic port_b_direction,
  input wire logic port_b_mailbox_sel,
  input wire logic port_b_enable,
  input wire logic [WIDTH-1:0] port_b_data_in,
  output logic [WIDTH-1:0] port_b_data_out,
  output logic port_b_out_ready,
  output logic port_b_in_ready,
  output logic port_b_almost_empty_n,
  output logic port_b_almost_full_n,
  input wire logic [`OFFSET_BITS-1:0] a_to_b_empty_offset,
  input wire logic [`OFFSET_BITS-1:0] a_to_b_full_offset,
  input wire logic [`OFFSET_BITS-1:0] b_to_a_empty_offset,
  input wire logic [`OFFSET_BITS-1:0] b_to_a_full_offset
);

  localparam int LW = `LEVEL_BITS;
  localparam int FALL_TICKS = `FALLTHROUGH_TICKS;

  // ----------------------------------------
  // pin sampling and port clock edges
  // ----------------------------------------
  dfs_pkg::port_pins_t a_pin;
  dfs_pkg::port_pins_t b_pin;
  dfs_pkg::port_pins_t a_s1_q;
  dfs_pkg::port_pins_t a_s2_q;
  dfs_pkg::port_pins_t b_s1_q;
  dfs_pkg::port_pins_t b_s2_q;
  logic a_clk_prev_q;
  logic b_clk_prev_q;

  assign a_pin = '{port_a_clock, port_a_select_n, port_a_direction,
                   port_a_mailbox_sel, port_a_enable, port_a_data_in};
  assign b_pin = '{port_b_clock, port_b_select_n, port_b_direction,
                   port_b_mailbox_sel, port_b_enable, port_b_data_in};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_s1_q <= '0;
      a_s2_q <= '0;
      b_s1_q <= '0;
      b_s2_q <= '0;
      a_clk_prev_q <= 1'b0;
      b_clk_prev_q <= 1'b0;
    end else begin
      a_s1_q <= a_pin;
      a_s2_q <= a_s1_q;
      b_s1_q <= b_pin;
      b_s2_q <= b_s1_q;
      a_clk_prev_q <= a_s2_q.clock;
      b_clk_prev_q <= b_s2_q.clock;
    end
  end

  // controls are taken from the same sampled word as the clock edge
  wire a_tick = a_s2_q.clock & ~a_clk_prev_q;
  wire b_tick = b_s2_q.clock & ~b_clk_prev_q;
  wire a_fifo_sel = a_tick & ~a_s2_q.select_n & a_s2_q.enable & ~a_s2_q.mailbox_sel;
  wire b_fifo_sel = b_tick & ~b_s2_q.select_n & b_s2_q.enable & ~b_s2_q.mailbox_sel;
  wire a_wr_try = a_fifo_sel & a_s2_q.direction;
  wire b_rd_try = b_fifo_sel & b_s2_q.direction;
  wire b_wr_try = b_fifo_sel & ~b_s2_q.direction;
  wire a_rd_try = a_fifo_sel & ~a_s2_q.direction;

  // ----------------------------------------
  // queues
  // ----------------------------------------
  dfs_pkg::flag_sync_t ir_a_q, ir_b_q, ae_a_q, ae_b_q, af_a_q, af_b_q;
  dfs_pkg::flag_sync_t av_a_q, av_b_q;
  logic or_a_q;
  logic or_b_q;
  logic [WIDTH-1:0] dout_a_q;
  logic [WIDTH-1:0] dout_b_q;

  logic ab_in_ready, ab_out_valid, ba_in_ready, ba_out_valid;
  logic [WIDTH-1:0] ab_out_data;
  logic [WIDTH-1:0] ba_out_data;
  logic [LW-1:0] ab_level;
  logic [LW-1:0] ba_level;

  wire wr1 = a_wr_try & ir_a_q.q & ab_in_ready;
  wire wr2 = b_wr_try & ir_b_q.q & ba_in_ready;

  // output register frees when empty or read in this tick
  wire b_consume = b_rd_try & or_b_q;
  wire a_consume = a_rd_try & or_a_q;
  wire pop1 = b_tick & (~or_b_q | b_consume) & av_b_q.q & ab_out_valid;
  wire pop2 = a_tick & (~or_a_q | a_consume) & av_a_q.q & ba_out_valid;

  flag_queue_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) a_to_b_queue (
    .clk(clk),
    .resetn(resetn),
    .in_valid(wr1),
    .in_ready(ab_in_ready),
    .in_data(a_s2_q.data),
    .out_valid(ab_out_valid),
    .out_ready(pop1),
    .out_data(ab_out_data),
    .level(ab_level)
  );

  flag_queue_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) b_to_a_queue (
    .clk(clk),
    .resetn(resetn),
    .in_valid(wr2),
    .in_ready(ba_in_ready),
    .in_data(b_s2_q.data),
    .out_valid(ba_out_valid),
    .out_ready(pop2),
    .out_data(ba_out_data),
    .level(ba_level)
  );

  // ----------------------------------------
  // flag conditions
  // ----------------------------------------
  // word moved to the output register has already left the level
  wire [LW-1:0] l1_wr = ab_level + LW'(wr1);
  wire [LW-1:0] l2_wr = ba_level + LW'(wr2);
  wire [LW-1:0] l1_rd = ab_level - LW'(pop1);
  wire [LW-1:0] l2_rd = ba_level - LW'(pop2);
  wire [LW-1:0] af1_lim = LW'(DEPTH) - LW'(a_to_b_full_offset) - LW'(1);
  wire [LW-1:0] af2_lim = LW'(DEPTH) - LW'(b_to_a_full_offset) - LW'(1);

  wire ir_a_cond = l1_wr < LW'(DEPTH);
  wire ir_b_cond = l2_wr < LW'(DEPTH);
  wire af_a_cond = l1_wr <= af1_lim;
  wire af_b_cond = l2_wr <= af2_lim;
  wire ae_b_cond = l1_rd > LW'(a_to_b_empty_offset);
  wire ae_a_cond = l2_rd > LW'(b_to_a_empty_offset);

  // falls at once on the port's own edge, rises only after two edges
  function automatic dfs_pkg::flag_sync_t step(input logic tick, input logic cond,
                                               input dfs_pkg::flag_sync_t f);
    step = f;
    if (tick) begin
      step.s1 = cond;
      step.q = cond & f.s1;
    end
  endfunction

  // ----------------------------------------
  // flag and output registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ir_a_q <= {2{`FLAG_RESET}};
      ir_b_q <= {2{`FLAG_RESET}};
      ae_a_q <= {2{`FLAG_RESET}};
      ae_b_q <= {2{`FLAG_RESET}};
      af_a_q <= {2{`FLAG_RESET}};
      af_b_q <= {2{`FLAG_RESET}};
      av_a_q <= {2{`FLAG_RESET}};
      av_b_q <= {2{`FLAG_RESET}};
    end else begin
      ir_a_q <= step(a_tick, ir_a_cond, ir_a_q);
      ir_b_q <= step(b_tick, ir_b_cond, ir_b_q);
      ae_b_q <= step(b_tick, ae_b_cond, ae_b_q);
      ae_a_q <= step(a_tick, ae_a_cond, ae_a_q);
      af_a_q <= step(a_tick, af_a_cond, af_a_q);
      af_b_q <= step(b_tick, af_b_cond, af_b_q);
      av_a_q <= step(a_tick, ba_out_valid, av_a_q);
      av_b_q <= step(b_tick, ab_out_valid, av_b_q);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      or_a_q <= `FLAG_RESET;
      or_b_q <= `FLAG_RESET;
      dout_a_q <= '0;
      dout_b_q <= '0;
    end else begin
      or_a_q <= pop2 | (or_a_q & ~a_consume);
      or_b_q <= pop1 | (or_b_q & ~b_consume);
      dout_a_q <= pop2 ? ba_out_data : dout_a_q;
      dout_b_q <= pop1 ? ab_out_data : dout_b_q;
    end
  end

  assign port_a_out_ready = or_a_q;
  assign port_b_out_ready = or_b_q;
  assign port_a_in_ready = ir_a_q.q;
  assign port_b_in_ready = ir_b_q.q;
  assign port_a_almost_empty_n = ae_a_q.q;
  assign port_b_almost_empty_n = ae_b_q.q;
  assign port_a_almost_full_n = af_a_q.q;
  assign port_b_almost_full_n = af_b_q.q;
  assign port_a_data_out = dout_a_q;
  assign port_b_data_out = dout_b_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // a ticks seen since the b-to-a queue turned non-empty while idle
  logic [3:0] wait_a_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_a_q <= '0;
    end else if (or_a_q || !ba_out_valid) begin
      wait_a_q <= '0;
    end else if (a_tick && wait_a_q != 4'hF) begin
      wait_a_q <= wait_a_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_FALLTHROUGH_BOUND: assert property (wait_a_q <= 4'(FALL_TICKS))
    else $error("b-to-a first word not loaded within three ticks");
  AST_IR_A_SPACE: assert property (port_a_in_ready |-> ab_level < LW'(DEPTH))
    else $error("a input ready high while queue full");
  AST_IR_B_SPACE: assert property (port_b_in_ready |-> ba_level < LW'(DEPTH))
    else $error("b input ready high while queue full");
  AST_AE_B_RISE: assert property ($rose(port_b_almost_empty_n) |-> $past(b_tick))
    else $error("b almost-empty rose off a b edge");
  AST_AE_A_LEVEL: assert property (port_a_almost_empty_n |-> ba_level > LW'(b_to_a_empty_offset))
    else $error("a almost-empty high at or below offset");
  AST_AF_A_LEVEL: assert property (port_a_almost_full_n |-> ab_level <= af1_lim)
    else $error("a almost-full high above limit");
  AST_AF_B_LEVEL: assert property (port_b_almost_full_n |-> ba_level <= af2_lim)
    else $error("b almost-full high above limit");
  AST_OR_LEAVES_LEVEL: assert property (pop2 && !wr2 |=> ba_level == $past(ba_level) - LW'(1))
    else $error("loaded word still counted in level");
  AST_AE_B_LEVEL: assert property (port_b_almost_empty_n |-> ab_level > LW'(a_to_b_empty_offset))
    else $error("b almost-empty high at or below offset");
  AST_AF_TWO_EDGES: assert property ($rose(port_a_almost_full_n) |-> $past(af_a_q.s1))
    else $error("a almost-full rose without a prior stage");
  AST_BLOCKED_WRITE: assert property (a_wr_try && !port_a_in_ready |=> ab_level <= $past(ab_level))
    else $error("write taken while input ready low");
  AST_SYNC_TWO_STAGE: assert property ($rose(port_a_in_ready) |-> $past(ir_a_q.s1))
    else $error("a input ready skipped a stage");

  COV_FALLTHROUGH: cover property ($rose(port_a_out_ready));
  COV_A_FULL: cover property ($fell(port_a_in_ready));
  COV_B_ALMOST_EMPTY: cover property ($rose(port_b_almost_empty_n));
  COV_B_READ: cover property (b_consume);

endmodule

`default_nettype wire

// *** dfs_consts.svh ***
`ifndef DFS_CONSTS_SVH
`define DFS_CONSTS_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define QUEUE_WORDS 512
`define DATA_BITS 36
`define OFFSET_BITS 9
`define LEVEL_BITS 16

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define FLAG_RESET 1'b0
`define CLK_PERIOD_NS 50
`define FALLTHROUGH_TICKS 3

`endif

// *** dfs_pkg.sv ***
`include "dfs_consts.svh"

package dfs_pkg;

  // one port's pins, sampled together so that controls line up with the clock edge
  typedef struct packed {
    logic clock;
    logic select_n;
    logic direction;
    logic mailbox_sel;
    logic enable;
    logic [`DATA_BITS-1:0] data;
  } port_pins_t;

  // two-stage flag synchroniser stepped by the clock edges of the port that shows the flag
  typedef struct packed {
    logic s1;
    logic q;
  } flag_sync_t;

endpackage

// *** flag_queue_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "dfs_consts.svh"

module flag_queue_fifo #(
  parameter int WIDTH = `DATA_BITS,
  parameter int DEPTH = `QUEUE_WORDS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [`LEVEL_BITS-1:0] level
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [`LEVEL_BITS-1:0] count_q;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (count_q < `LEVEL_BITS'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem[rptr_q];
  assign level = count_q;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else begin
      wptr_q <= push ? bump(wptr_q) : wptr_q;
      rptr_q <= pop ? bump(rptr_q) : rptr_q;
      count_q <= count_q + `LEVEL_BITS'(push) - `LEVEL_BITS'(pop);
    end
  end

endmodule

`default_nettype wire

// *** port_model.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "dfs_consts.svh"

// ----------------------------------------
// bus master on one port of the block
// ----------------------------------------
module port_model #(
  parameter int HALF = 6
) (
  input wire logic clk,
  output logic port_clock,
  output logic select_n,
  output logic direction,
  output logic mailbox_sel,
  output logic enable,
  output logic [`DATA_BITS-1:0] data
);
  // free-running port clock, kept well under clk/4 so the block can sample it
  initial begin
    port_clock = 1'b0;
    select_n = 1'b1;
    direction = 1'b0;
    mailbox_sel = 1'b0;
    enable = 1'b0;
    data = '0;
    forever begin
      repeat (HALF) @(negedge clk);
      port_clock = ~port_clock;
    end
  end

  // controls change mid-cycle, so they are steady across the sampling tick
  task automatic op(input logic sn, input logic dir, input logic mb, input logic en,
                    input logic [`DATA_BITS-1:0] d);
    @(negedge port_clock);
    select_n = sn;
    direction = dir;
    mailbox_sel = mb;
    enable = en;
    // released data toggles so a stale word never looks valid
    data = en ? d : ~data;
    @(posedge port_clock);
  endtask

  task automatic idle();
    op(1'b1, direction, 1'b0, 1'b0, '0);
  endtask

  task automatic xfer(input logic sn, input logic dir, input logic mb, input logic en,
                      input logic [`DATA_BITS-1:0] d);
    op(sn, dir, mb, en, d);
    idle();
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge port_clock);
    @(negedge port_clock);
  endtask
endmodule

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "dfs_consts.svh"

module tb_top;
  typedef logic [`DATA_BITS-1:0] word_t;
  typedef struct packed {
    logic [4:0] k;
    logic [3:0] exp;
  } row_t;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk;
  logic resetn;
  wire logic a_ck, a_sn, a_dir, a_mb, a_en, b_ck, b_sn, b_dir, b_mb, b_en;
  wire word_t a_din, b_din;
  word_t a_dout, b_dout;
  logic a_or, a_ir, a_ae_n, a_af_n, b_or, b_ir, b_ae_n, b_af_n;
  int mismatches = 0;
  int n_tests = 0;
  int k, n;
  logic [`OFFSET_BITS-1:0] ab_x = 9'h001, ab_y = 9'h001, ba_x = 9'h002, ba_y = 9'h002;
  // writes into b-to-a so far against {out ready a, empty a, full b, in ready b}
  row_t rows [6] = '{'{5'h01, 4'hB}, '{5'h03, 4'hB}, '{5'h04, 4'hF},
                     '{5'h0E, 4'hF}, '{5'h0F, 4'hD}, '{5'h11, 4'hC}};

  port_model #(.HALF(6)) pa (.clk(clk), .port_clock(a_ck), .select_n(a_sn),
    .direction(a_dir), .mailbox_sel(a_mb), .enable(a_en), .data(a_din));
  port_model #(.HALF(7)) pb (.clk(clk), .port_clock(b_ck), .select_n(b_sn),
    .direction(b_dir), .mailbox_sel(b_mb), .enable(b_en), .data(b_din));

  dual_fifo_flag_sync #(.DEPTH(16)) DUT (.clk(clk), .resetn(resetn),
    .port_a_clock(a_ck), .port_a_select_n(a_sn), .port_a_direction(a_dir),
    .port_a_mailbox_sel(a_mb), .port_a_enable(a_en), .port_a_data_in(a_din),
    .port_a_data_out(a_dout), .port_a_out_ready(a_or), .port_a_in_ready(a_ir),
    .port_a_almost_empty_n(a_ae_n), .port_a_almost_full_n(a_af_n),
    .port_b_clock(b_ck), .port_b_select_n(b_sn), .port_b_direction(b_dir),
    .port_b_mailbox_sel(b_mb), .port_b_enable(b_en), .port_b_data_in(b_din),
    .port_b_data_out(b_dout), .port_b_out_ready(b_or), .port_b_in_ready(b_ir),
    .port_b_almost_empty_n(b_ae_n), .port_b_almost_full_n(b_af_n),
    .a_to_b_empty_offset(ab_x), .a_to_b_full_offset(ab_y),
    .b_to_a_empty_offset(ba_x), .b_to_a_full_offset(ba_y));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic word_t word(input int i);
    return 36'hA5A50000 + word_t'(i);
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d, checks %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // whole run needs some 2400 clk
  initial begin
    #2000000;
    mismatches++;
    finish_test();
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    check({a_or, a_ir, a_ae_n, a_af_n, b_or, b_ir, b_ae_n, b_af_n}, 8'h00, "reset flags");
    check(a_dout | b_dout, 36'h0, "reset data");
    @(negedge clk);
    resetn = 1'b1;
    pa.settle(2);
    pb.settle(2);
    check({a_ir, a_af_n, b_ir, b_af_n, a_or, a_ae_n, b_or, b_ae_n}, 8'hF0, "after reset");
    // first word into an empty queue: count port a ticks until it shows
    pb.op(1'b0, 1'b0, 1'b0, 1'b1, word(0));
    n = 0;
    fork
      pb.idle();
      while (a_or !== 1'b1 && n < 8) begin
        pa.settle(1);
        n++;
      end
    join
    check(n >= 3 && n <= 4, 1'b1, "fall-through ticks");
    check(a_dout, word(0), "fall-through word");
    k = 1;
    foreach (rows[r]) begin
      while (k < rows[r].k) begin
        pb.xfer(1'b0, 1'b0, 1'b0, 1'b1, word(k));
        k++;
      end
      pa.settle(3);
      check({a_or, a_ae_n, b_af_n, b_ir}, rows[r].exp, "b-to-a flags");
    end
    pb.xfer(1'b0, 1'b0, 1'b0, 1'b1, 36'h0DEADBEEF);
    for (int i = 0; i < 17; i++) begin
      check(a_dout, word(i), "b-to-a data");
      pa.xfer(1'b0, 1'b0, 1'b0, 1'b1, '0);
      if (i == 0) begin
        pb.settle(3);
        check(b_ir, 1'b1, "b space");
      end
    end
    pa.settle(3);
    check({a_or, a_ae_n, b_af_n}, 3'h1, "b-to-a drained");
    // mailbox and deselected writes must not reach the queue
    pa.xfer(1'b0, 1'b1, 1'b1, 1'b1, word(99));
    pa.xfer(1'b1, 1'b1, 1'b0, 1'b1, word(98));
    pa.xfer(1'b0, 1'b1, 1'b0, 1'b0, word(95));
    pb.xfer(1'b0, 1'b0, 1'b1, 1'b1, word(96));
    pb.settle(4);
    check({b_or, a_or}, 2'h0, "no stray word");
    for (int i = 0; i < 17; i++) begin
      pa.xfer(1'b0, 1'b1, 1'b0, 1'b1, word(i + 32));
      if (i == 1 || i == 2) begin
        pb.settle(3);
        check({b_or, b_ae_n}, {1'b1, i == 2}, "a-to-b fill");
      end
    end
    pa.settle(0);
    check({a_ir, a_af_n}, 2'h0, "a-to-b full");
    pa.xfer(1'b0, 1'b1, 1'b0, 1'b1, word(97));
    pb.xfer(1'b0, 1'b1, 1'b0, 1'b1, '0);
    pa.settle(3);
    check({a_ir, a_af_n, b_dout}, {2'h2, word(33)}, "a space");
    pb.xfer(1'b0, 1'b1, 1'b0, 1'b1, '0);
    pa.settle(3);
    check(a_af_n, 1'b1, "a below mark");
    // second reset with other offsets; thresholds only change while in reset
    @(negedge clk);
    resetn = 1'b0;
    {ab_x, ab_y, ba_x, ba_y} = {9'h000, 9'h00F, 9'h000, 9'h00F};
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check({a_or, a_ir, a_ae_n, a_af_n, b_or, b_ir, b_ae_n, b_af_n}, 8'h00, "reset release");
    check(a_dout | b_dout, 36'h0, "reset release data");
    pa.settle(2);
    pb.settle(2);
    check({a_ir, a_af_n, b_ir, b_af_n, a_or, a_ae_n, b_or, b_ae_n}, 8'hF0, "after second reset");
    for (int i = 0; i < 2; i++) begin
      pb.xfer(1'b0, 1'b0, 1'b0, 1'b1, word(i + 64));
      pa.xfer(1'b0, 1'b1, 1'b0, 1'b1, word(i + 80));
    end
    pa.settle(3);
    pb.settle(3);
    check({a_or, a_ae_n, a_af_n, b_or, b_ae_n, b_af_n}, 6'h36, "new offsets");
    check(a_dout, word(64), "b-to-a word after reset");
    check(b_dout, word(80), "a-to-b word after reset");
    finish_test();
  end
endmodule

`default_nettype wire
